/* bench/ppl_pins.sv */
// Purpose: external pins facing the port
// Assumes: the bench drives a pin only while the port leaves it
// Notes: a floating pin without pull-up toggles, so a stale level never reads back
`timescale 1ns/1ns
module ppl_pins (
  input wire logic clk_i,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_n_i,
  input wire logic [7:0] pullup_en_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_in_o
);
  // ****
  // wire level
  // ****
  logic [7:0] noise = 8'h5a;
  always @(posedge clk_i) begin
    noise <= ~noise;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n_i[i]) pad_in_o[i] = pad_out_i[i];
      else if (ext_en_i[i]) pad_in_o[i] = ext_val_i[i];
      else if (pullup_en_i[i]) pad_in_o[i] = 1'b1;
      else pad_in_o[i] = noise[i];
    end
  end
endmodule : ppl_pins

/* bench/tb_top.sv */
// Purpose: self-checking bench of the port block
// Assumes: classic Wishbone, one-cycle ack
// Notes: pads are checked a few cycles after the writes of the drive, read and owner tests
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 0, rst_i = 1, por = 1, ow = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0, pin, pout, oen, pu, slw, smt, i2b, xen = 0, xv = 0, aoe = 0;
  logic [7:0] v, o, a;
  logic [3:0] sel = 4'hf;
  logic [31:0] wd = 0, rdat, r;
  logic ack, po = 0, pi2c = 0, pin_sel;
  int fails = 0, samples_checked = 0;
  // ****
  // harness
  // ****
  initial forever #5 clk_i = ~clk_i;
  ppl_port dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por), .pin_select_one_way_option_i(ow),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in_i(pin), .pad_out_o(pout),
    .pad_oe_n_o(oen), .pullup_en_o(pu), .slew_limit_o(slw), .schmitt_sel_o(smt),
    .i2c_buffer_o(i2b), .periph_out_i(po), .periph_i2c_i(pi2c), .periph_in_o(pin_sel),
    .analog_out_en_i(aoe));
  ppl_pins pins (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_n_i(oen), .pullup_en_i(pu),
    .ext_en_i(xen), .ext_val_i(xv), .pad_in_o(pin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] dv);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wd <= {24'h0, dv};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask : bus
  task automatic wr(input logic [7:0] ad, input logic [7:0] dv);
    bus(1, ad, dv);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    bus(0, ad, 8'h00);
    chk(r, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic key(input logic [7:0] b);
    wr(8'h20, 8'h55);
    wr(8'h20, 8'haa);
    wr(8'h20, b);
  endtask : key
  // pad view: {oe_n, driven value}; out is don't-care where the pin is released
  function automatic logic [15:0] drv(input logic [7:0] d, od, s, ae);
    logic [7:0] oe;
    oe = d | ae | (od & s);
    return {oe, s & ~od & ~oe};
  endfunction : drv
  task automatic finish_test;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    tick(20000);
    fails++;
    finish_test;
  end
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(32'h00a8));
    tick(8);
    rst_i <= 0;
    por <= 0;
    rd(8'h04, 8'hff);
    rd(8'h0c, 8'hff);
    rd(8'h08, 8'h00);
    for (int k = 8'h10; k <= 8'h28; k += 4) rd(k[7:0], 8'h00);
    rd(8'h3c, 8'h00);
    chk(oen, 8'hff);
    $display("reset done");
    wr(8'h04, 8'h00);
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      o = $urandom;
      a = $urandom;
      aoe <= $urandom;
      wr(8'h14, o);
      wr(8'h0c, a);
      wr(k[0] ? 8'h00 : 8'h08, v);
      tick(3);
      chk({oen, pout & ~oen}, drv(8'h00, o, v, aoe));
      rd(8'h08, v);
    end
    aoe <= 0;
    $display("drive done");
    wr(8'h04, 8'hff);
    xen <= 8'hff;
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      a = (k == 0) ? 8'h00 : 8'($urandom);
      xv <= v;
      wr(8'h0c, a);
      wr(8'h28, k[7:0]);
      tick(4);
      rd(8'h00, v & ~a);
      chk(pin_sel, v[k] & ~a[k]);
      wr(8'h10, v);
      wr(8'h18, o);
      wr(8'h1c, a);
      tick(3);
      chk({pu, slw, smt}, {v, o, a});
    end
    xen <= 0;
    $display("read done");
    wr(8'h04, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h24, 8'h0f);
    wr(8'h28, 8'h01);
    wr(8'h1c, 8'hff);
    po <= 1;
    tick(3);
    chk({oen, pout & ~oen}, drv(8'h00, 8'h00, 8'h0f, 8'h00));
    pi2c <= 1;
    tick(3);
    chk(oen, 8'h0f);
    chk({i2b, smt}, 16'h06f9);
    pi2c <= 0;
    $display("owner done");
    key(8'h01);
    rd(8'h20, 8'h01);
    wr(8'h24, 8'hf0);
    rd(8'h24, 8'h0f);
    wr(8'h28, 8'h05);
    rd(8'h28, 8'h01);
    wr(8'h20, 8'h55);
    wr(8'h04, 8'h00);
    wr(8'h20, 8'haa);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h01);
    key(8'h00);
    rd(8'h20, 8'h00);
    wr(8'h24, 8'hf0);
    rd(8'h24, 8'hf0);
    ow <= 1;
    rst_i <= 1;
    tick(2);
    rst_i <= 0;
    rd(8'h24, 8'hf0);
    key(8'h01);
    key(8'h00);
    rd(8'h20, 8'h01);
    por <= 1;
    ow <= 0;
    tick(2);
    por <= 0;
    rd(8'h24, 8'h00);
    rd(8'h20, 8'h00);
    $display("lock done");
    finish_test;
  end
endmodule : tb_top

/* logic/ppl_map.svh */
// Purpose: offsets, reset values and keys of the port block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: definitions only
`ifndef PPL_MAP_SVH
`define PPL_MAP_SVH
// ************
// offsets
// ************
`define PPL_OFS_PIN_LEVEL 8'h00
`define PPL_OFS_DIRECTION 8'h04
`define PPL_OFS_LATCH 8'h08
`define PPL_OFS_ANALOG 8'h0c
`define PPL_OFS_PULLUP 8'h10
`define PPL_OFS_OPEN_DRAIN 8'h14
`define PPL_OFS_SLEW 8'h18
`define PPL_OFS_THRESHOLD 8'h1c
`define PPL_OFS_LOCK 8'h20
`define PPL_OFS_SEL_OUT 8'h24
`define PPL_OFS_SEL_IN 8'h28
// ************
// fields and values
// ************
`define PPL_LOCK_BIT 0
`define PPL_RST_DIRECTION 8'hff
`define PPL_RST_ANALOG 8'hff
`define PPL_RST_LATCH 8'h00
`define PPL_RST_CFG 8'h00
`define PPL_RST_SEL_IN 3'h0
`define PPL_KEY_FIRST 8'h55
`define PPL_KEY_SECOND 8'haa
`define PPL_I2C_PINS 8'h06
`endif

/* logic/ppl_pkg.sv */
// Purpose: types of the port block
// Assumes: constants live in ppl_map.svh
// Notes: state of the block is one packed struct
package ppl_pkg;
  typedef enum logic [1:0] {
    PPL_SEQ_IDLE = 2'b00,
    PPL_SEQ_KEY1 = 2'b01,
    PPL_SEQ_ARMED = 2'b11
  } ppl_seq_t;

  typedef struct packed {
    logic [7:0] lat;
    logic [7:0] dir;
    logic [7:0] ans;
    logic [7:0] wpu;
    logic [7:0] odc;
    logic [7:0] slr;
    logic [7:0] inl;
    logic [7:0] sel_out;
    logic [2:0] sel_in;
    logic lock;
    logic oneway;
    logic ow_done;
    ppl_seq_t seq;
    logic ack;
    logic [31:0] dat;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pad_out;
    logic [7:0] pad_oe_n;
    logic [7:0] od;
    logic [7:0] pull;
    logic [7:0] slew;
    logic [7:0] schmitt;
    logic [7:0] i2c_buf;
    logic periph_in;
  } ppl_state_t;
endpackage : ppl_pkg

/* logic/ppl_port.sv */
// Purpose: eight-pin general-purpose port with pin-select ownership and lock
// Assumes: classic Wishbone slave, single clock, por_i and rst_i synchronous
// Notes: pad outputs lag register writes by one cycle
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "ppl_map.svh"

module ppl_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic pin_select_one_way_option_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pad_in_i,
  output logic [7:0] pad_out_o,
  output logic [7:0] pad_oe_n_o,
  output logic [7:0] pullup_en_o,
  output logic [7:0] slew_limit_o,
  output logic [7:0] schmitt_sel_o,
  output logic [7:0] i2c_buffer_o,
  input wire logic periph_out_i,
  input wire logic periph_i2c_i,
  output logic periph_in_o,
  input wire logic [7:0] analog_out_en_i
);

  // ************
  // state
  // ************
  ppl_pkg::ppl_state_t st;
  ppl_pkg::ppl_state_t next_st;

  logic [7:0] pin_dig;
  logic [7:0] src_w;
  logic [7:0] od_w;
  logic [7:0] drv_w;
  logic [7:0] i2c_w;
  logic [7:0] i2c_pins;
  logic req;
  logic wr;
  logic [7:0] wd;

  assign i2c_pins = `PPL_I2C_PINS;
  // analog pins read zero; only the second sync stage is read
  assign pin_dig = st.pin_s2 & ~st.ans;
  assign req = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];

  // ************
  // per-pin drive
  // ************
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      // pin-select ownership replaces the latch as source
      assign src_w[i] = st.sel_out[i] ? periph_out_i : st.lat[i];
      assign i2c_w[i] = st.sel_out[i] & periph_i2c_i;
      assign od_w[i] = st.odc[i] | i2c_w[i];
      // analog select plays no part in the driver
      assign drv_w[i] = ~st.dir[i] & ~analog_out_en_i[i] &
                        (~od_w[i] | ~src_w[i]);
    end
  endgenerate

  // ************
  // next state
  // ************
  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.pin_s1 = pad_in_i;
    next_st.pin_s2 = st.pin_s1;

    // register reads
    if (req) begin
      next_st.dat = 32'h0000_0000;
      case (wb_adr_i)
        `PPL_OFS_PIN_LEVEL: begin
          next_st.dat[7:0] = pin_dig;
        end
        `PPL_OFS_DIRECTION: begin
          next_st.dat[7:0] = st.dir;
        end
        `PPL_OFS_LATCH: begin
          next_st.dat[7:0] = st.lat;
        end
        `PPL_OFS_ANALOG: begin
          next_st.dat[7:0] = st.ans;
        end
        `PPL_OFS_PULLUP: begin
          next_st.dat[7:0] = st.wpu;
        end
        `PPL_OFS_OPEN_DRAIN: begin
          next_st.dat[7:0] = st.odc;
        end
        `PPL_OFS_SLEW: begin
          next_st.dat[7:0] = st.slr;
        end
        `PPL_OFS_THRESHOLD: begin
          next_st.dat[7:0] = st.inl;
        end
        `PPL_OFS_LOCK: begin
          next_st.dat[`PPL_LOCK_BIT] = st.lock;
        end
        `PPL_OFS_SEL_OUT: begin
          next_st.dat[7:0] = st.sel_out;
        end
        `PPL_OFS_SEL_IN: begin
          next_st.dat[2:0] = st.sel_in;
        end
        default: begin
          next_st.dat = 32'h0000_0000;
        end
      endcase
    end

    // register writes
    if (wr) begin
      case (wb_adr_i)
        // software modifies what it read from the pins
        `PPL_OFS_PIN_LEVEL: begin
          next_st.lat = wd;
        end
        `PPL_OFS_LATCH: begin
          next_st.lat = wd;
        end
        `PPL_OFS_DIRECTION: begin
          next_st.dir = wd;
        end
        `PPL_OFS_ANALOG: begin
          next_st.ans = wd;
        end
        `PPL_OFS_PULLUP: begin
          next_st.wpu = wd;
        end
        `PPL_OFS_OPEN_DRAIN: begin
          next_st.odc = wd;
        end
        `PPL_OFS_SLEW: begin
          next_st.slr = wd;
        end
        `PPL_OFS_THRESHOLD: begin
          next_st.inl = wd;
        end
        `PPL_OFS_SEL_OUT: begin
          if (!st.lock) begin
            next_st.sel_out = wd;
          end
        end
        `PPL_OFS_SEL_IN: begin
          if (!st.lock) begin
            next_st.sel_in = wd[2:0];
          end
        end
        default: begin
          next_st.lat = st.lat;
        end
      endcase

      // key sequence; any other write restarts it
      if (wb_adr_i == `PPL_OFS_LOCK) begin
        case (st.seq)
          ppl_pkg::PPL_SEQ_IDLE: begin
            next_st.seq = (wd == `PPL_KEY_FIRST) ?
                          ppl_pkg::PPL_SEQ_KEY1 : ppl_pkg::PPL_SEQ_IDLE;
          end
          ppl_pkg::PPL_SEQ_KEY1: begin
            if (wd == `PPL_KEY_SECOND) begin
              next_st.seq = ppl_pkg::PPL_SEQ_ARMED;
            end else if (wd == `PPL_KEY_FIRST) begin
              next_st.seq = ppl_pkg::PPL_SEQ_KEY1;
            end else begin
              next_st.seq = ppl_pkg::PPL_SEQ_IDLE;
            end
          end
          ppl_pkg::PPL_SEQ_ARMED: begin
            next_st.seq = ppl_pkg::PPL_SEQ_IDLE;
            // one-way: once set, the lock sticks until reset
            if (!st.ow_done) begin
              next_st.lock = wd[`PPL_LOCK_BIT];
              next_st.ow_done = st.oneway & wd[`PPL_LOCK_BIT];
            end
          end
          default: begin
            next_st.seq = ppl_pkg::PPL_SEQ_IDLE;
          end
        endcase
      end else begin
        next_st.seq = ppl_pkg::PPL_SEQ_IDLE;
      end
    end

    // pad controls, registered so every output is a flop
    next_st.pad_out = src_w & ~od_w;
    next_st.pad_oe_n = ~drv_w;
    next_st.od = od_w;
    next_st.pull = st.wpu;
    next_st.slew = st.slr;
    // I2C buffers exist only on the designated pins
    next_st.i2c_buf = i2c_w & i2c_pins;
    next_st.schmitt = st.inl & ~(i2c_w & i2c_pins);
    next_st.periph_in = pin_dig[st.sel_in];

    // resets: only power-on clears pin-select selections
    if (por_i || rst_i) begin
      next_st = '0;
      next_st.dir = `PPL_RST_DIRECTION;
      next_st.ans = `PPL_RST_ANALOG;
      next_st.lat = `PPL_RST_LATCH;
      next_st.wpu = `PPL_RST_CFG;
      next_st.odc = `PPL_RST_CFG;
      next_st.slr = `PPL_RST_CFG;
      next_st.inl = `PPL_RST_CFG;
      next_st.pad_oe_n = 8'hff;
      next_st.seq = ppl_pkg::PPL_SEQ_IDLE;
      next_st.oneway = pin_select_one_way_option_i;
      next_st.sel_out = por_i ? `PPL_RST_CFG : st.sel_out;
      next_st.sel_in = por_i ? `PPL_RST_SEL_IN : st.sel_in;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // ************
  // outputs
  // ************
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign pad_out_o = st.pad_out;
  assign pad_oe_n_o = st.pad_oe_n;
  assign pullup_en_o = st.pull;
  assign slew_limit_o = st.slew;
  assign schmitt_sel_o = st.schmitt;
  assign i2c_buffer_o = st.i2c_buf;
  assign periph_in_o = st.periph_in;

  // ************
  // checks
  // ************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);

  logic wr_lock;
  assign wr_lock = wr && (wb_adr_i == `PPL_OFS_LOCK);

  sequence s_key_first;
    wr_lock && wd == `PPL_KEY_FIRST && st.seq == ppl_pkg::PPL_SEQ_IDLE;
  endsequence

  sequence s_armed_write;
    wr_lock && st.seq == ppl_pkg::PPL_SEQ_ARMED && !st.ow_done;
  endsequence

  AST_INPUT_OFF: assert property (
    (st.dir == 8'hff) |=> (pad_oe_n_o == 8'hff))
    else $error("input pins are driven");

  AST_DRIVE_LATCH: assert property (
    (st.dir == 8'h00 && st.sel_out == 8'h00 && st.odc == 8'h00 &&
     analog_out_en_i == 8'h00)
    |=> (pad_oe_n_o == 8'h00 && pad_out_o == $past(st.lat)))
    else $error("output pins do not show the latch");

  AST_READ_PINS: assert property (
    (req && !wb_we_i && wb_adr_i == `PPL_OFS_PIN_LEVEL)
    |=> (wb_ack_o && wb_dat_o[7:0] == $past(st.pin_s2 & ~st.ans)))
    else $error("pin read value wrong");

  AST_LATCH_WRITE: assert property (
    (wr && (wb_adr_i == `PPL_OFS_LATCH || wb_adr_i == `PPL_OFS_PIN_LEVEL))
    |=> (st.lat == $past(wd)))
    else $error("latch missed a write");

  AST_ANALOG_ZERO: assert property (
    (req && !wb_we_i && wb_adr_i == `PPL_OFS_PIN_LEVEL)
    |=> ((wb_dat_o[7:0] & $past(st.ans)) == 8'h00))
    else $error("analog pin reads one");

  AST_ANALOG_RESET: assert property (
    $fell(rst_i) |-> (st.ans == 8'hff))
    else $error("analog select not set after reset");

  AST_OD_SINK: assert property (
    (st.odc != 8'h00) |=> ((~pad_oe_n_o & pad_out_o & $past(st.odc)) == 8'h00))
    else $error("open-drain pin sources current");

  AST_I2C_OD: assert property (
    (periph_i2c_i && st.sel_out != 8'h00)
    |=> ((~pad_oe_n_o & pad_out_o & $past(st.sel_out)) == 8'h00))
    else $error("I2C pin not open-drain");

  AST_LOCK_HOLDS: assert property (
    (st.lock && wr && wb_adr_i == `PPL_OFS_SEL_OUT)
    |=> $stable(st.sel_out))
    else $error("selection changed while locked");

  // a reset clears the lock with no key, so the edge after it is exempt
  AST_LOCK_KEYED: assert property (
    ($changed(st.lock) && !$past(rst_i || por_i))
    |-> $past(st.seq == ppl_pkg::PPL_SEQ_ARMED && wr_lock))
    else $error("lock changed without key sequence");

  AST_KEY_ADVANCE: assert property (
    s_key_first |=> (st.seq == ppl_pkg::PPL_SEQ_KEY1))
    else $error("first key not taken");

  AST_ARMED_APPLY: assert property (
    s_armed_write |=> (st.lock == $past(wd[`PPL_LOCK_BIT]) &&
                       st.seq == ppl_pkg::PPL_SEQ_IDLE))
    else $error("armed write did not set lock");

  AST_ONEWAY: assert property (
    st.ow_done |=> (st.lock && st.ow_done))
    else $error("one-way lock released");

  AST_RESTART: assert property (
    (wr && wb_adr_i != `PPL_OFS_LOCK) |=> (st.seq == ppl_pkg::PPL_SEQ_IDLE))
    else $error("foreign write kept sequence");

  AST_PULLUP_COPY: assert property (
    1'b1 |=> (pullup_en_o == $past(st.wpu)))
    else $error("pull-up output does not follow register");

  AST_SLEW_COPY: assert property (
    1'b1 |=> (slew_limit_o == $past(st.slr)))
    else $error("slew output does not follow register");

  AST_SEL_IN_LOCK: assert property (
    (st.lock && wr && wb_adr_i == `PPL_OFS_SEL_IN) |=> $stable(st.sel_in))
    else $error("input selection changed while locked");

  AST_POR_CLEARS: assert property (
    $fell(por_i) |-> (st.sel_out == 8'h00 && st.sel_in == 3'h0 && !st.lock))
    else $error("power-on reset left selections");

  AST_PERIPH_ANALOG: assert property (
    1'b1 |=> !(periph_in_o && $past(st.ans[st.sel_in])))
    else $error("analog pin reaches peripheral input");

endmodule : ppl_port
